// ---- common/rpes_pkg.sv ----
// Purpose: Shared constants and types for the remote point exchange block
// Assumes: 50 MHz core clock, 32-bit AHB-Lite register bus
// Notes:   Offsets are byte addresses of aligned 32-bit registers
package rpes_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int N_DEV    = 16;
  localparam int DEV_W    = 4;
  localparam int N_RIN    = 32;
  localparam int N_ROUT   = 64;
  localparam int N_PAIR   = 128;
  localparam int N_PREDEF = 32;
  localparam int N_USER   = 32;
  localparam int SEL_W    = 6;
  localparam int ID_W     = 32;
  localparam int MS_W     = 16;
  localparam int HOLD_W   = 18;
  localparam int HOLD_MULT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS   = 20;
  localparam int MS_NS    = 1000000;
  localparam int TICK_CYC = MS_NS / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Pair encoding
  localparam logic [1:0] PAIR_ON     = 2'h2;
  localparam logic [1:0] PAIR_OFF    = 2'h1;
  localparam logic [1:0] PAIR_UNUSED = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] REG_UPDATE    = 8'h00;
  localparam logic [7:0] REG_LOCAL_ID  = 8'h04;
  localparam logic [7:0] REG_ONLINE    = 8'h08;
  localparam logic [7:0] REG_RIN_STATE = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h14;
  localparam logic [7:0] REG_DEV_BASE  = 8'h40;
  localparam logic [7:0] REG_CFG_BASE  = 8'h80;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  localparam logic [MS_W-1:0] UPDATE_RST = 16'h03E8;
  localparam logic [ID_W-1:0] LOCAL_ID_RST = 32'h0000_0000;

  // Remote input config fields
  localparam int CFG_DEV_LSB  = 0;
  localparam int CFG_SEL_LSB  = 4;
  localparam int CFG_DFLT_LSB = 12;
  localparam int CFG_W        = 14;

  // Interrupt bits
  localparam int IRQ_TX   = 0;
  localparam int IRQ_RX   = 1;
  localparam int IRQ_LOST = 2;
  localparam int IRQ_W    = 3;

  typedef enum logic [1:0] {
    DFLT_ON,
    DFLT_OFF,
    DFLT_LATEST_ON,
    DFLT_LATEST_OFF
  } rpes_dflt_e;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } rpes_tx_e;

endpackage

// ---- src/rpes_hold_slot.sv ----
// Purpose: Hold timer and link status for one remote device
// Assumes: ms_tick is a one-cycle pulse once per millisecond
// Notes:   A load always wins over an expiry in the same cycle
`timescale 1ns/1ps
module rpes_hold_slot
  import rpes_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      ms_tick,
  input  wire logic                      load,
  input  wire logic [rpes_pkg::HOLD_W-1:0] hold_ms,
  output logic                           online,
  output logic                           expired
);

  logic [HOLD_W-1:0] timer_q;
  logic [HOLD_W-1:0] timer_d;
  logic              online_q;
  logic              online_d;
  logic              expired_d;
  logic              expired_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    timer_d   = timer_q;
    online_d  = online_q;
    expired_d = 1'b0;
    if (load)
    begin
      timer_d  = hold_ms;
      online_d = 1'b1;
    end
    else if (ms_tick && online_q)
    begin
      if (timer_q <= HOLD_W'(1))
      begin
        timer_d   = '0;
        online_d  = 1'b0;
        expired_d = 1'b1;
      end
      else
      begin
        timer_d = timer_q - HOLD_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      timer_q   <= '0;
      online_q  <= 1'b0;
      expired_q <= 1'b0;
    end
    else
    begin
      timer_q   <= timer_d;
      online_q  <= online_d;
      expired_q <= expired_d;
    end
  end

  assign online  = online_q;
  assign expired = expired_q;

  ////////////////////////////////////////////////////////////////////////////
  chk_load_online: assert property (@(posedge core_clk) disable iff (rst)
    load |=> online && timer_q == $past(hold_ms))
    else $error("hold timer not loaded from message");

  chk_expire_offline: assert property (@(posedge core_clk) disable iff (rst)
    (ms_tick && online && timer_q <= HOLD_W'(1) && !load) |=> !online && expired)
    else $error("expired device still online");

endmodule

// ---- src/rpes_top.sv ----
// Purpose: Point state message framer, sender and receiver supervisor
// Assumes: Message ports face an Ethernet MAC on the same clock
// Notes:   Registers on AHB-Lite, zero wait states, always OKAY
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - Messages reserve 128 two-bit entries, one per digital point.
// - First 32 entries are predefined pairs, next 32 user pairs used.
// - One message is sent right after reset completes.
// - Any change of an included point triggers a message.
// - Without changes, resend when the update interval expires.
// - Sent hold time is three times the update interval.
// - Every message carries the local originator identity.
// - Accept received data only from configured remote device ids.
// - Accepted message loads that device's hold timer with its hold time.
// - Hold timeout marks device offline and applies default point states.
// - Arriving message updates point states and restarts the hold timer.
// - Per-device online status is visible; zero means offline.
// - 32 remote inputs received, 64 remote outputs transmitted.
// - Messages travel over the Ethernet link behind the message ports.
// - Each remote input picks one of 64 pairs from one device.
// - Default is on, off, or latest falling back to on or off.
// - Defaults apply from startup until the device's first message.
module rpes_top
  import rpes_pkg::*;
#(
  parameter int TICK_CYC = rpes_pkg::TICK_CYC
)
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  output logic                               irq,
  input  wire logic [rpes_pkg::N_ROUT-1:0]   tx_points,
  output logic                               tx_valid,
  input  wire logic                          tx_ready,
  output logic [rpes_pkg::ID_W-1:0]          tx_origin,
  output logic [rpes_pkg::HOLD_W-1:0]        tx_hold_ms,
  output logic [2*rpes_pkg::N_PAIR-1:0]      tx_pairs,
  input  wire logic                          rx_valid,
  input  wire logic [rpes_pkg::ID_W-1:0]     rx_origin,
  input  wire logic [rpes_pkg::HOLD_W-1:0]   rx_hold_ms,
  input  wire logic [2*rpes_pkg::N_PAIR-1:0] rx_pairs,
  output logic [rpes_pkg::N_DEV-1:0]         dev_online,
  output logic [rpes_pkg::N_RIN-1:0]         remote_in
);
  import rpes_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [MS_W-1:0]  upd_q, upd_d;
  logic [ID_W-1:0]  lid_q, lid_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [ID_W-1:0]  dev_id_q [N_DEV];
  logic [ID_W-1:0]  dev_id_d [N_DEV];
  logic [CFG_W-1:0] cfg_q [N_RIN];
  logic [CFG_W-1:0] cfg_d [N_RIN];
  logic             wr_q, wr_d;
  logic [7:0]       addr_q, addr_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             aphase;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;

  // Transmit and receive state
  logic [TICK_W-1:0]       tick_cnt_q, tick_cnt_d;
  logic                    ms_tick;
  logic [MS_W-1:0]         upd_cnt_q, upd_cnt_d;
  logic [MS_W-1:0]         upd_eff;
  rpes_tx_e                tx_st_q, tx_st_d;
  logic                    boot_q, boot_d;
  logic [N_ROUT-1:0]       last_q, last_d;
  logic [ID_W-1:0]         org_q, org_d;
  logic [HOLD_W-1:0]       hold_q, hold_d;
  logic [2*N_PAIR-1:0]     pairs_q, pairs_d;
  logic [2*N_PAIR-1:0]     frame_pairs;
  logic                    send_now;
  logic                    period_due;
  logic                    tx_done;
  logic [N_DEV-1:0]        match;
  logic [N_DEV-1:0]        expired;
  logic [N_RIN-1:0]        rin_q, rin_d;
  logic [N_RIN-1:0]        last_rx_q, last_rx_d;
  logic [N_RIN-1:0]        known_q, known_d;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  assign aphase    = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    if (a[7])
      v = 32'(cfg_q[a[6:2]]);
    else if (a[6])
      v = dev_id_q[a[5:2]];
    else
    begin
      case (a)
        REG_UPDATE:    v = 32'(upd_q);
        REG_LOCAL_ID:  v = lid_q;
        REG_ONLINE:    v = 32'(dev_online);
        REG_RIN_STATE: v = rin_q;
        REG_IRQ_STAT:  v = 32'(stat_q);
        REG_IRQ_MASK:  v = 32'(mask_q);
        default:       v = '0;
      endcase
    end
    return v;
  endfunction

  always_comb
  begin
    wr_d    = aphase && hwrite;
    addr_d  = aphase ? haddr[7:0] : addr_q;
    rdata_d = (aphase && !hwrite) ? rd_val(haddr[7:0]) : rdata_q;
    upd_d   = upd_q;
    lid_d   = lid_q;
    mask_d  = mask_q;
    w1c     = '0;
    dev_id_d = dev_id_q;
    cfg_d    = cfg_q;
    if (wr_q)
    begin
      if (addr_q[7])
        cfg_d[addr_q[6:2]] = hwdata[CFG_W-1:0];
      else if (addr_q[6])
        dev_id_d[addr_q[5:2]] = hwdata;
      else
      begin
        case (addr_q)
          REG_UPDATE:   upd_d  = hwdata[MS_W-1:0];
          REG_LOCAL_ID: lid_d  = hwdata;
          REG_IRQ_STAT: w1c    = hwdata[IRQ_W-1:0];
          REG_IRQ_MASK: mask_d = hwdata[IRQ_W-1:0];
          default:      w1c    = '0;
        endcase
      end
    end
    // An event in the clearing cycle survives the clear
    stat_d = (stat_q & ~w1c) | ev;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_q    <= 1'b0;
      addr_q  <= '0;
      rdata_q <= '0;
      upd_q   <= UPDATE_RST;
      lid_q   <= LOCAL_ID_RST;
      stat_q  <= '0;
      mask_q  <= '0;
      for (int i = 0; i < N_DEV; i++)
        dev_id_q[i] <= '0;
      for (int i = 0; i < N_RIN; i++)
        cfg_q[i] <= '0;
    end
    else
    begin
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      rdata_q  <= rdata_d;
      upd_q    <= upd_d;
      lid_q    <= lid_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      dev_id_q <= dev_id_d;
      cfg_q    <= cfg_d;
    end
  end

  assign ev  = {|expired, |match, tx_done};
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit framer
  assign ms_tick    = tick_cnt_q == TICK_W'(TICK_CYC - 1);
  assign upd_eff    = (upd_q == '0) ? MS_W'(1) : upd_q;
  assign period_due = upd_cnt_q >= upd_eff;
  assign send_now   = boot_q || last_q != tx_points || period_due;
  assign tx_done    = tx_st_q == TX_SEND && tx_ready;

  genvar k;
  generate
    for (k = 0; k < N_PAIR; k++)
    begin : g_pair
      if (k < N_PREDEF + N_USER)
      begin : g_used
        assign frame_pairs[2*k +: 2] = tx_points[k] ? PAIR_ON : PAIR_OFF;
      end
      else
      begin : g_spare
        assign frame_pairs[2*k +: 2] = PAIR_UNUSED;
      end
    end
  endgenerate

  always_comb
  begin
    tick_cnt_d = ms_tick ? '0 : tick_cnt_q + TICK_W'(1);
    upd_cnt_d  = (ms_tick && !period_due) ? upd_cnt_q + MS_W'(1) : upd_cnt_q;
    tx_st_d    = tx_st_q;
    boot_d     = boot_q;
    last_d     = last_q;
    org_d      = org_q;
    hold_d     = hold_q;
    pairs_d    = pairs_q;
    case (tx_st_q)
      TX_IDLE:
      begin
        if (send_now)
        begin
          tx_st_d = TX_SEND;
          boot_d  = 1'b0;
          last_d  = tx_points;
          org_d   = lid_q;
          hold_d  = HOLD_W'(HOLD_MULT) * HOLD_W'(upd_eff);
          pairs_d = frame_pairs;
        end
      end
      TX_SEND:
      begin
        if (tx_ready)
        begin
          tx_st_d   = TX_IDLE;
          upd_cnt_d = '0;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tick_cnt_q <= '0;
      upd_cnt_q  <= '0;
      tx_st_q    <= TX_IDLE;
      boot_q     <= 1'b1;
      last_q     <= '0;
      org_q      <= '0;
      hold_q     <= '0;
      pairs_q    <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      upd_cnt_q  <= upd_cnt_d;
      tx_st_q    <= tx_st_d;
      boot_q     <= boot_d;
      last_q     <= last_d;
      org_q      <= org_d;
      hold_q     <= hold_d;
      pairs_q    <= pairs_d;
    end
  end

  assign tx_valid   = tx_st_q == TX_SEND;
  assign tx_origin  = org_q;
  assign tx_hold_ms = hold_q;
  assign tx_pairs   = pairs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receive supervisor
  genvar d;
  generate
    for (d = 0; d < N_DEV; d++)
    begin : g_dev
      // Id zero marks an unused slot so an idle link cannot match it
      assign match[d] = rx_valid && dev_id_q[d] != '0
                        && rx_origin == dev_id_q[d];
      rpes_hold_slot u_slot (
        .core_clk (core_clk),
        .rst      (rst),
        .ms_tick  (ms_tick),
        .load     (match[d]),
        .hold_ms  (rx_hold_ms),
        .online   (dev_online[d]),
        .expired  (expired[d])
      );
    end
  endgenerate

  genvar r;
  generate
    for (r = 0; r < N_RIN; r++)
    begin : g_rin
      logic [DEV_W-1:0] dsel;
      logic [SEL_W-1:0] psel;
      logic [1:0]       pv;
      rpes_dflt_e       dflt;
      assign dsel = cfg_q[r][CFG_DEV_LSB +: DEV_W];
      assign psel = cfg_q[r][CFG_SEL_LSB +: SEL_W];
      assign dflt = rpes_dflt_e'(cfg_q[r][CFG_DFLT_LSB +: 2]);
      assign pv   = rx_pairs[2*psel +: 2];
      always_comb
      begin
        last_rx_d[r] = last_rx_q[r];
        known_d[r]   = known_q[r];
        // Transitional or bad pair codes leave the last state alone
        if (match[dsel] && (pv == PAIR_ON || pv == PAIR_OFF))
        begin
          last_rx_d[r] = pv == PAIR_ON;
          known_d[r]   = 1'b1;
        end
        if (dev_online[dsel])
          rin_d[r] = last_rx_q[r];
        else
        begin
          case (dflt)
            DFLT_ON:         rin_d[r] = 1'b1;
            DFLT_OFF:        rin_d[r] = 1'b0;
            DFLT_LATEST_ON:  rin_d[r] = known_q[r] ? last_rx_q[r] : 1'b1;
            DFLT_LATEST_OFF: rin_d[r] = known_q[r] ? last_rx_q[r] : 1'b0;
            default:         rin_d[r] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rin_q     <= '0;
      last_rx_q <= '0;
      known_q   <= '0;
    end
    else
    begin
      rin_q     <= rin_d;
      last_rx_q <= last_rx_d;
      known_q   <= known_d;
    end
  end

  assign remote_in = rin_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_tx_load;
    tx_st_q == TX_IDLE && send_now;
  endsequence

  sequence s_tx_held;
    tx_valid && !tx_ready;
  endsequence

  chk_boot_send: assert property (@(posedge core_clk)
    $fell(rst) |-> tx_st_q == TX_IDLE ##1 tx_valid)
    else $error("no message after reset");

  chk_change_send: assert property (@(posedge core_clk) disable iff (rst)
    (tx_st_q == TX_IDLE && tx_points != last_q) |=> tx_valid)
    else $error("point change did not start a message");

  chk_hold_triple: assert property (@(posedge core_clk) disable iff (rst)
    s_tx_load |=> tx_hold_ms == HOLD_W'(HOLD_MULT) * HOLD_W'($past(upd_eff)))
    else $error("hold time is not three update intervals");

  chk_origin_id: assert property (@(posedge core_clk) disable iff (rst)
    s_tx_load |=> tx_origin == $past(lid_q))
    else $error("origin id does not match local id");

  chk_frame_stable: assert property (@(posedge core_clk) disable iff (rst)
    s_tx_held |=> tx_valid && $stable(tx_pairs) && $stable(tx_hold_ms))
    else $error("message changed while stalled");

  chk_period_bound: assert property (@(posedge core_clk) disable iff (rst)
    period_due && tx_st_q == TX_IDLE |=> tx_valid ##[0:1000] upd_cnt_q == '0)
    else $error("periodic resend missed");

  chk_foreign_drop: assert property (@(posedge core_clk) disable iff (rst)
    (rx_valid && match == '0) |=> $stable(last_rx_q) && $stable(known_q))
    else $error("message from unknown origin accepted");

  chk_default_on: assert property (@(posedge core_clk) disable iff (rst)
    (!dev_online[cfg_q[0][CFG_DEV_LSB +: DEV_W]]
     && cfg_q[0][CFG_DFLT_LSB +: 2] == 2'(DFLT_ON)) |=> remote_in[0])
    else $error("forced-on default not applied");

  chk_clear_race: assert property (@(posedge core_clk) disable iff (rst)
    (|match && w1c[IRQ_RX]) |=> stat_q[IRQ_RX])
    else $error("receive event lost to a clear");

endmodule

// ---- dv/rpes_peer_model.sv ----
// Purpose: Far side model: Ethernet MAC plus remote devices on the LAN
// Assumes: Same clock as the block; messages are taken and sent whole
// Notes:   Slow mode stalls tx_ready three cycles in four
`timescale 1ns/1ps
module rpes_peer_model
(
  input  wire logic                          core_clk,
  input  wire logic                          slow,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire logic [rpes_pkg::ID_W-1:0]     tx_origin,
  input  wire logic [rpes_pkg::HOLD_W-1:0]   tx_hold_ms,
  input  wire logic [2*rpes_pkg::N_PAIR-1:0] tx_pairs,
  output logic                               rx_valid,
  output logic [rpes_pkg::ID_W-1:0]          rx_origin,
  output logic [rpes_pkg::HOLD_W-1:0]        rx_hold_ms,
  output logic [2*rpes_pkg::N_PAIR-1:0]      rx_pairs
);
  import rpes_pkg::*;
  logic [1:0]          stall_q;
  int                  n_msgs;
  logic [ID_W-1:0]     got_origin;
  logic [HOLD_W-1:0]   got_hold;
  logic [2*N_PAIR-1:0] got_pairs;

  initial
  begin
    stall_q    = 2'h0;
    n_msgs     = 0;
    tx_ready   = 1'b0;
    rx_valid   = 1'b0;
    rx_origin  = '0;
    rx_hold_ms = '0;
    rx_pairs   = '0;
    got_pairs  = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message is taken whole at the edge where valid meets ready
  always @(posedge core_clk)
  begin
    stall_q  <= stall_q + 2'h1;
    tx_ready <= !slow || (stall_q == 2'h2);
    if (tx_valid && tx_ready)
    begin
      got_origin <= tx_origin;
      got_hold   <= tx_hold_ms;
      got_pairs  <= tx_pairs;
      n_msgs     <= n_msgs + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote device message, one cycle; lines show garbage once released
  task automatic send(input logic [ID_W-1:0] id, input logic [HOLD_W-1:0] hold,
                      input logic [2*N_PAIR-1:0] pairs);
    @(posedge core_clk);
    rx_valid   <= 1'b1;
    rx_origin  <= id;
    rx_hold_ms <= hold;
    rx_pairs   <= pairs;
    @(posedge core_clk);
    rx_valid   <= 1'b0;
    rx_origin  <= ~id;
    rx_hold_ms <= ~hold;
    rx_pairs   <= ~pairs;
  endtask
endmodule

// ---- dv/test_rpes_top.sv ----
// Purpose: Self-checking bench for the point exchange supervisor
// Assumes: Millisecond tick shortened to 10 cycles
// Notes:   Timer windows allow one tick of phase slack
`timescale 1ns/1ps
module test_rpes_top;
  import rpes_pkg::*;
  localparam int TICK = 10;
  logic                core_clk, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic                slow, tx_valid, tx_ready, rx_valid;
  logic [31:0]         haddr, hwdata, hrdata, rd, seed, lid, id_a;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [N_ROUT-1:0]   tx_points, v;
  logic [ID_W-1:0]     tx_origin, rx_origin;
  logic [HOLD_W-1:0]   tx_hold_ms, rx_hold_ms;
  logic [2*N_PAIR-1:0] tx_pairs, rx_pairs, pairs;
  logic [N_DEV-1:0]    dev_online;
  logic [N_RIN-1:0]    remote_in;
  int                  n_errors, total_checks, cyc, base;

  rpes_top #(.TICK_CYC(TICK)) i_rpes_top (
    .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .tx_points,
    .tx_valid, .tx_ready, .tx_origin, .tx_hold_ms, .tx_pairs, .rx_valid,
    .rx_origin, .rx_hold_ms, .rx_pairs, .dev_online, .remote_in);
  rpes_peer_model i_rpes_peer_model (
    .core_clk, .slow, .tx_valid, .tx_ready, .tx_origin, .tx_hold_ms,
    .tx_pairs, .rx_valid, .rx_origin, .rx_hold_ms, .rx_pairs);

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Points map one to one onto the first 64 entries, the rest unused
  function automatic logic [255:0] exp_pairs(input logic [63:0] p);
    exp_pairs = '0;
    for (int k = 0; k < 64; k++)
      exp_pairs[2*k +: 2] = p[k] ? PAIR_ON : PAIR_OFF;
  endfunction

  task automatic check_reg(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_port(input logic [255:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Single word transfer; waits on hready rather than assuming no wait
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e);
    ahb(1'b0, a, 32'h0);
    check_reg(rd & m, e, "register read");
    check_reg(32'(hresp), 32'h0, "okay response");
  endtask

  task automatic wait_msgs(input int n);
    cyc = 0;
    while (i_rpes_peer_model.n_msgs < n && cyc < 3000)
    begin
      @(posedge core_clk);
      cyc++;
    end
    check_reg(32'(i_rpes_peer_model.n_msgs >= n), 32'h1, "message count");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = HSIZE_WORD; hwdata = '0; tx_points = '0; slow = 1'b0;
    seed = 32'h62633FE0; n_errors = 0; total_checks = 0; pairs = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1 check_reg(remote_in, 32'hFFFFFFFF, "startup defaults");
    wait_msgs(1);
    check_port(i_rpes_peer_model.got_pairs, exp_pairs('0), "pairs");
    check_reg(32'(i_rpes_peer_model.got_hold), 32'(HOLD_MULT * UPDATE_RST), "hold");
    check_reg(i_rpes_peer_model.got_origin, LOCAL_ID_RST, "origin");
    rdchk(REG_UPDATE, 32'hFFFF, 32'(UPDATE_RST));
    rdchk(REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h3C, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    // Change messages under a stalling MAC
    lid = xrand();
    ahb(1'b1, REG_LOCAL_ID, lid);
    ahb(1'b1, REG_UPDATE, 32'd4);
    slow <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      v = {xrand(), xrand()};
      if (i == 0) v = '1;
      @(posedge core_clk);
      tx_points <= v;
      cyc = 0;
      while (i_rpes_peer_model.got_pairs !== exp_pairs(v) && cyc < 20)
      begin
        @(posedge core_clk);
        cyc++;
      end
      check_port(i_rpes_peer_model.got_pairs, exp_pairs(v), "pairs");
    end
    check_reg(32'(i_rpes_peer_model.got_hold), 32'(HOLD_MULT * 4), "hold");
    check_reg(i_rpes_peer_model.got_origin, lid, "origin");
    $display("test change done");
    // Periodic resend with points held still
    slow <= 1'b0;
    base = i_rpes_peer_model.n_msgs;
    wait_msgs(base + 1);
    wait_msgs(base + 2);
    check_reg(32'(cyc >= 30 && cyc <= 60), 32'h1, "update period");
    // Narrow accesses are refused, so the interval must keep its value
    hsize <= 3'h0;
    ahb(1'b1, REG_UPDATE, 32'h9);
    hsize <= HSIZE_WORD;
    rdchk(REG_UPDATE, 32'hFFFF, 32'h4);
    $display("test periodic done");
    // Receive side: device 0 feeds inputs 0 and 1, input 2 never heard
    id_a = xrand() | 32'h1;
    ahb(1'b1, REG_DEV_BASE, id_a);
    ahb(1'b1, REG_CFG_BASE, 32'h1050);
    ahb(1'b1, REG_CFG_BASE + 8'h04, 32'h2280);
    ahb(1'b1, REG_CFG_BASE + 8'h08, 32'h3001);
    ahb(1'b1, REG_IRQ_MASK, 32'h2);
    for (int k = 0; k < 8; k++)
      pairs[32*k +: 32] = xrand();
    pairs[11:10] = PAIR_ON;
    pairs[81:80] = PAIR_OFF;
    i_rpes_peer_model.send(id_a ^ 32'h1, 18'd3, pairs);
    rdchk(REG_ONLINE, 32'hFFFF, 32'h0);
    check_reg(32'(remote_in[2:0]), 32'h2, "defaults");
    i_rpes_peer_model.send(id_a, 18'd3, pairs);
    repeat (2) @(posedge core_clk);
    #1 check_reg(32'(dev_online[0]), 32'h1, "online");
    check_reg(32'(remote_in[2:0]), 32'h1, "inputs");
    check_reg(32'(irq), 32'h1, "irq raised");
    rdchk(REG_IRQ_STAT, 32'h6, 32'h2);
    ahb(1'b1, REG_IRQ_STAT, 32'h7);
    @(posedge core_clk);
    #1 check_reg(32'(irq), 32'h0, "irq cleared");
    // Second message restarts the timer well before it runs out, and
    // lands in the same cycle as a clear of its own status bit
    fork
      ahb(1'b1, REG_IRQ_STAT, 32'h2);
      begin
        @(posedge core_clk);
        i_rpes_peer_model.send(id_a, 18'd3, pairs);
      end
    join
    rdchk(REG_IRQ_STAT, 32'h2, 32'h2);
    repeat (15) @(posedge core_clk);
    #1 check_reg(32'(dev_online[0]), 32'h1, "still online");
    repeat (25) @(posedge core_clk);
    #1 check_reg(32'(dev_online[0]), 32'h0, "offline");
    check_reg(32'(remote_in[2:0]), 32'h0, "fallback");
    rdchk(REG_IRQ_STAT, 32'h4, 32'h4);
    rdchk(REG_ONLINE, 32'hFFFF, 32'h0);
    $display("test receive done");
    final_report();
  end
endmodule
